// File: wtx_pkg.sv
// constants, types and register map of the inductive power transmitter controller
package wtx_pkg;

    typedef logic signed [21:0] wtx_wide_t;

    // clock and probe timing
    localparam int CLK_MHZ       = 50;
    localparam int PING_WIN_US   = 70;
    localparam int PING_WIN_CYC  = PING_WIN_US * CLK_MHZ;
    localparam int PING_GAP_US   = 40;
    localparam int PING_GAP_CYC  = PING_GAP_US * CLK_MHZ;
    localparam int TMR_W         = 13;

    // operating frequency in hz
    localparam wtx_wide_t F_PING_HI   = 22'h02BF20;
    localparam wtx_wide_t F_PING_LO   = 22'h027100;
    localparam wtx_wide_t F_PING_STEP = 22'h001388;
    localparam wtx_wide_t F_MIN       = 22'h01ADB0;
    localparam wtx_wide_t F_MAX       = 22'h0320C8;

    // inverter supply in 0.5 mV units
    localparam wtx_wide_t V_PING      = 22'h005DC0;
    localparam wtx_wide_t V_MIN       = 22'h001388;
    localparam wtx_wide_t V_MAX       = 22'h0059D8;

    // duty cycle in 0.1 percent units
    localparam wtx_wide_t D_MIN       = 22'h000000;
    localparam wtx_wide_t D_MAX       = 22'h0001F4;

    // pid gains and output limits
    localparam wtx_wide_t KP          = 22'h000001;
    localparam wtx_wide_t LIM_FREQ    = 22'h004E20;
    localparam wtx_wide_t LIM_VOLT    = 22'h0005DC;
    localparam wtx_wide_t LIM_DUTY    = 22'h004E20;

    // register offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SS_MIN = 8'h08;
    localparam logic [7:0] OFS_FREQ   = 8'h0C;
    localparam logic [7:0] OFS_VOLT   = 8'h10;
    localparam logic [7:0] OFS_DUTY   = 8'h14;
    localparam logic [7:0] OFS_CUR    = 8'h18;

    // field positions and reset values
    localparam int CTRL_EN_BIT        = 0;
    localparam int ST_FAIL_BIT        = 6;
    localparam int ST_CFG_BIT         = 7;
    localparam logic [7:0] SS_MIN_RST = 8'h01;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PING = 4'h2,
        ST_GAP  = 4'h4,
        ST_XFER = 4'h8
    } wtx_state_e;

    typedef enum logic [1:0] {
        PATH_FREQ = 2'h0,
        PATH_VOLT = 2'h1,
        PATH_DUTY = 2'h2
    } wtx_path_e;

endpackage

// File: wtx_power_ctrl.sv
// digital control unit of the inductive power transmitter
//
// Function
// - probe starts between 160 and 180 kHz with inverter supply at 12.0 V
// - no signal strength packet after probe: power signal is removed
// - retries go consecutively lower in probe range until acceptable strength
// - transfer keeps frequency 110 to 205 kHz at 50 percent duty
// - duty below 50 percent only while frequency sits at 205 kHz
// - inverter supply 2.5 to 11.5 V with 10 mV or finer steps
// - higher inverter supply means more transferred power
// - pid loop controls frequency, supply voltage or duty cycle
// - frequency first; voltage or duty only at frequency range ends
// - coil current amplitude measured at 7 mA or finer as feedback
// - frequency loop: gain 1, output limit 20000, step 1 Hz
// - voltage loop: gain 1, output limit 1500, step 0.5 mV
// - duty loop: gain 1, output limit 20000, step 0.1 percent
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module wtx_power_ctrl
    import wtx_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // decoded receiver packets
    input  wire logic        pkt_ss_valid,
    input  wire logic [7:0]  pkt_ss_value,
    input  wire logic        pkt_ce_valid,
    input  wire logic [7:0]  pkt_ce_value,
    input  wire logic        pkt_cfg_valid,
    input  wire logic        pkt_cfg_res_sens_dis,
    // current sense, 1 mA per lsb
    input  wire logic [11:0] coil_current_ma,
    // inverter drive
    output logic             power_on,
    output logic [17:0]      operating_frequency,
    output logic [15:0]      inverter_voltage,
    output logic [9:0]       duty_cycle
);

    wtx_state_e        state_ff;
    wtx_state_e        nxt_state;
    wtx_path_e         path_ff;
    wtx_path_e         nxt_path;
    logic [17:0]       freq_ff;
    logic [15:0]       volt_ff;
    logic [9:0]        duty_ff;
    logic [TMR_W-1:0]  tmr_ff;
    logic              en_ff;
    logic [7:0]        ss_min_ff;
    logic              fail_ff;
    logic              cfg_err_ff;
    logic [31:0]       prdata_ff;
    logic              slverr_ff;

    wtx_wide_t         freq_w;
    wtx_wide_t         volt_w;
    wtx_wide_t         duty_w;
    wtx_wide_t         err;
    wtx_wide_t         pid;
    wtx_wide_t         lim;
    wtx_wide_t         nxt_freq;
    wtx_wide_t         nxt_volt;
    wtx_wide_t         nxt_duty;
    logic signed [20:0] prod;

    logic              setup;
    logic              wr_acc;
    logic              ss_ok;
    logic              tmr_done;
    logic              mapped;

    function automatic wtx_wide_t clamp(input wtx_wide_t v, input wtx_wide_t lo,
                                        input wtx_wide_t hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    assign freq_w   = wtx_wide_t'({4'h0, freq_ff});
    assign volt_w   = wtx_wide_t'({6'h00, volt_ff});
    assign duty_w   = wtx_wide_t'({12'h000, duty_ff});
    assign setup    = psel & ~penable;
    assign wr_acc   = psel & penable & pwrite & clk_en;
    assign ss_ok    = pkt_ss_valid & (pkt_ss_value >= ss_min_ff);
    assign tmr_done = (tmr_ff == '0);

    // control error turned into current error, then proportional term
    always_comb begin
        prod = $signed({1'b0, coil_current_ma, 8'h00}) >>> 8;
        prod = prod * $signed({{13{pkt_ce_value[7]}}, pkt_ce_value});
        err  = wtx_wide_t'(prod >>> 7);
        pid  = err * KP;
    end

    // path choice: frequency first, voltage or duty only at range ends
    always_comb begin
        if (err > 0) begin
            if (duty_w < D_MAX) begin
                nxt_path = PATH_DUTY;
            end else if (freq_w > F_MIN) begin
                nxt_path = PATH_FREQ;
            end else begin
                nxt_path = PATH_VOLT;
            end
        end else begin
            if (freq_w < F_MAX) begin
                nxt_path = PATH_FREQ;
            end else if (volt_w > V_MIN) begin
                nxt_path = PATH_VOLT;
            end else begin
                nxt_path = PATH_DUTY;
            end
        end
    end

    // controlled variable update for the chosen path
    always_comb begin
        nxt_freq = freq_w;
        nxt_volt = volt_w;
        nxt_duty = duty_w;
        lim      = LIM_FREQ;
        unique case (nxt_path)
            PATH_FREQ: begin
                lim      = LIM_FREQ;
                nxt_freq = clamp(freq_w - clamp(pid, -lim, lim), F_MIN, F_MAX);
            end
            PATH_VOLT: begin
                lim      = LIM_VOLT;
                nxt_volt = clamp(volt_w + clamp(pid, -lim, lim), V_MIN, V_MAX);
            end
            PATH_DUTY: begin
                lim      = LIM_DUTY;
                nxt_duty = clamp(duty_w + clamp(pid, -lim, lim), D_MIN, D_MAX);
            end
            default: begin
                lim      = LIM_FREQ;
            end
        endcase
    end

    // probe and transfer sequence
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: if (en_ff) nxt_state = ST_PING;
            ST_PING: begin
                if (!en_ff) begin
                    nxt_state = ST_IDLE;
                end else if (ss_ok) begin
                    nxt_state = ST_XFER;
                end else if (tmr_done) begin
                    nxt_state = (freq_w > F_PING_LO) ? ST_GAP : ST_IDLE;
                end
            end
            ST_GAP: begin
                if (!en_ff) begin
                    nxt_state = ST_IDLE;
                end else if (tmr_done) begin
                    nxt_state = ST_PING;
                end
            end
            ST_XFER: if (!en_ff) nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // probe window and gap timer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tmr_ff <= '0;
        end else if (clk_en) begin
            if (nxt_state == ST_PING && state_ff != ST_PING) begin
                tmr_ff <= TMR_W'(PING_WIN_CYC - 1);
            end else if (nxt_state == ST_GAP && state_ff != ST_GAP) begin
                tmr_ff <= TMR_W'(PING_GAP_CYC - 1);
            end else if (!tmr_done) begin
                tmr_ff <= tmr_ff - 1'b1;
            end
        end
    end

    // operating point registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            freq_ff <= F_PING_HI[17:0];
            volt_ff <= V_PING[15:0];
            duty_ff <= D_MAX[9:0];
            path_ff <= PATH_FREQ;
        end else if (clk_en) begin
            if (state_ff == ST_IDLE && nxt_state == ST_PING) begin
                freq_ff <= F_PING_HI[17:0];
                volt_ff <= V_PING[15:0];
                duty_ff <= D_MAX[9:0];
            end else if (state_ff == ST_GAP && nxt_state == ST_PING) begin
                freq_ff <= 18'(clamp(freq_w - F_PING_STEP, F_PING_LO, F_PING_HI));
            end else if (state_ff == ST_PING && nxt_state == ST_XFER) begin
                volt_ff <= V_MAX[15:0];
                duty_ff <= D_MAX[9:0];
            end else if (state_ff == ST_XFER && pkt_ce_valid) begin
                freq_ff <= nxt_freq[17:0];
                volt_ff <= nxt_volt[15:0];
                duty_ff <= nxt_duty[9:0];
                path_ff <= nxt_path;
            end
        end
    end

    // inverter drive outputs, power removed outside probe and transfer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            power_on <= 1'b0;
        end else if (clk_en) begin
            power_on <= (nxt_state == ST_PING) || (nxt_state == ST_XFER);
        end
    end

    assign operating_frequency = freq_ff;
    assign inverter_voltage    = volt_ff;
    assign duty_cycle          = duty_ff;

    // control and threshold registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            en_ff     <= 1'b0;
            ss_min_ff <= SS_MIN_RST;
        end else if (wr_acc) begin
            if (paddr == OFS_CTRL) en_ff <= pwdata[CTRL_EN_BIT];
            if (paddr == OFS_SS_MIN) ss_min_ff <= pwdata[7:0];
        end
    end

    // sticky flags, hardware set wins over write-one-to-clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fail_ff    <= 1'b0;
            cfg_err_ff <= 1'b0;
        end else if (clk_en) begin
            if (state_ff == ST_PING && nxt_state == ST_IDLE && en_ff) begin
                fail_ff <= 1'b1;
            end else if (wr_acc && paddr == OFS_STATUS && pwdata[ST_FAIL_BIT]) begin
                fail_ff <= 1'b0;
            end
            if (pkt_cfg_valid && pkt_cfg_res_sens_dis) begin
                cfg_err_ff <= 1'b1;
            end else if (wr_acc && paddr == OFS_STATUS && pwdata[ST_CFG_BIT]) begin
                cfg_err_ff <= 1'b0;
            end
        end
    end

    // apb read data captured in the setup cycle, zero wait answer
    always_comb begin
        mapped = 1'b1;
        unique case (paddr)
            OFS_CTRL, OFS_STATUS, OFS_SS_MIN, OFS_FREQ, OFS_VOLT, OFS_DUTY, OFS_CUR: ;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prdata_ff <= 32'h0000_0000;
            slverr_ff <= 1'b0;
        end else if (clk_en && setup) begin
            slverr_ff <= ~mapped;
            unique case (paddr)
                OFS_CTRL:   prdata_ff <= {31'h0000_0000, en_ff};
                OFS_STATUS: prdata_ff <= {24'h00_0000, cfg_err_ff, fail_ff, path_ff, state_ff};
                OFS_SS_MIN: prdata_ff <= {24'h00_0000, ss_min_ff};
                OFS_FREQ:   prdata_ff <= {14'h0000, freq_ff};
                OFS_VOLT:   prdata_ff <= {16'h0000, volt_ff};
                OFS_DUTY:   prdata_ff <= {22'h00_0000, duty_ff};
                OFS_CUR:    prdata_ff <= {20'h0_0000, coil_current_ma};
                default:    prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = 1'b1;
    assign pslverr = slverr_ff & psel & penable;

endmodule

// File: wtx_rx_model.sv
// receiver packet source across the coil link
`timescale 1ns/1ps
module wtx_rx_model (
    // clock and link power
    input  wire logic  clk_sys,
    input  wire logic  power_on,
    // decoded packets
    output logic       pkt_ss_valid,
    output logic [7:0] pkt_ss_value,
    output logic       pkt_ce_valid,
    output logic [7:0] pkt_ce_value,
    output logic       pkt_cfg_valid,
    output logic       pkt_cfg_res_sens_dis
);
    initial begin
        {pkt_ss_valid, pkt_ce_valid, pkt_cfg_valid, pkt_cfg_res_sens_dis} = 4'h0;
        {pkt_ss_value, pkt_ce_value} = 16'h0000;
    end
    // kind 0 strength, 1 control error, 2 configuration, after dl idle cycles
    task automatic send(input int kind, input logic [7:0] v, input int dl);
        repeat (dl + 1) @(posedge clk_sys);
        if (power_on !== 1'h1) return;
        pkt_ss_valid <= kind == 0;
        pkt_ce_valid <= kind == 1;
        pkt_cfg_valid <= kind == 2;
        {pkt_ss_value, pkt_ce_value} <= {v, v};
        pkt_cfg_res_sens_dis <= v[0];
        @(posedge clk_sys);
        {pkt_ss_valid, pkt_ce_valid, pkt_cfg_valid} <= 3'h0;
        {pkt_ss_value, pkt_ce_value} <= ~{v, v};
        pkt_cfg_res_sens_dis <= ~v[0];
    endtask
endmodule

// File: wtx_power_ctrl_asserts.sv
// port assertions of the transmitter controller
`timescale 1ns/1ps
module wtx_power_ctrl_chk
    import wtx_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // packets and drive
    input wire logic        pkt_ss_valid,
    input wire logic        pkt_ce_valid,
    input wire logic        power_on,
    input wire logic [17:0] operating_frequency,
    input wire logic [15:0] inverter_voltage,
    input wire logic [9:0]  duty_cycle
);
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [12:0] on_cnt_ff;
    logic        got_ss_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !power_on) begin
            on_cnt_ff <= 13'h0000;
            got_ss_ff <= 1'h0;
        end else begin
            got_ss_ff <= got_ss_ff | pkt_ss_valid;
            on_cnt_ff <= on_cnt_ff + {12'h000, !got_ss_ff};
        end
    end
    property p_start;
        $rose(power_on) |-> operating_frequency >= F_PING_LO
            && operating_frequency <= F_PING_HI && inverter_voltage == V_PING;
    endproperty
    a_start: assert property (p_start) else $error("bad probe start");
    property p_win;
        !got_ss_ff |-> on_cnt_ff <= 13'(PING_WIN_CYC + 2);
    endproperty
    a_win: assert property (p_win) else $error("probe too long");
    property p_frng;
        power_on |-> operating_frequency >= F_MIN && operating_frequency <= F_MAX;
    endproperty
    a_frng: assert property (p_frng) else $error("frequency range");
    property p_dlow;
        duty_cycle < D_MAX |-> operating_frequency == F_MAX;
    endproperty
    a_dlow: assert property (p_dlow) else $error("duty below half");
    property p_vrng;
        inverter_voltage >= V_MIN && inverter_voltage <= V_PING;
    endproperty
    a_vrng: assert property (p_vrng) else $error("voltage range");
    property p_one;
        pkt_ce_valid |=> $changed(operating_frequency) + $changed(inverter_voltage)
            + $changed(duty_cycle) <= 2'h1;
    endproperty
    a_one: assert property (p_one) else $error("several paths moved");
    property p_ffirst;
        pkt_ce_valid && operating_frequency > F_MIN && operating_frequency < F_MAX
            |=> $stable(inverter_voltage);
    endproperty
    a_ffirst: assert property (p_ffirst) else $error("voltage moved");
    property p_vstep;
        power_on && $past(power_on) |-> inverter_voltage + 16'h05DC >= $past(inverter_voltage)
            && inverter_voltage <= $past(inverter_voltage) + 16'h05DC;
    endproperty
    a_vstep: assert property (p_vstep) else $error("voltage step");
    c_ping: cover property ($rose(power_on));
    c_duty: cover property (duty_cycle < D_MAX);
    c_vmin: cover property (inverter_voltage == V_MIN);
endmodule
bind wtx_power_ctrl wtx_power_ctrl_chk u_chk (.clk_sys, .rst_n, .pkt_ss_valid,
    .pkt_ce_valid, .power_on, .operating_frequency, .inverter_voltage, .duty_cycle);

// File: tb_top.sv
// self-checking bench of the transmitter controller
`timescale 1ns/1ps
module tb_top;
    import wtx_pkg::*;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, power_on, err;
    logic        clk_en;
    logic        pkt_ss_valid, pkt_ce_valid, pkt_cfg_valid, pkt_cfg_res_sens_dis;
    logic [7:0]  paddr, pkt_ss_value, pkt_ce_value;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] coil_current_ma;
    logic [17:0] operating_frequency;
    logic [15:0] inverter_voltage;
    logic [9:0]  duty_cycle;
    int          errors = 0;
    int          checks = 0;
    int          ef, ev, ed;
    wtx_power_ctrl uut (
        .clk_sys, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pkt_ss_valid, .pkt_ss_value, .pkt_ce_valid,
        .pkt_ce_value, .pkt_cfg_valid, .pkt_cfg_res_sens_dis, .coil_current_ma,
        .power_on, .operating_frequency, .inverter_voltage, .duty_cycle
    );
    wtx_rx_model rx (
        .clk_sys, .power_on, .pkt_ss_valid, .pkt_ss_value, .pkt_ce_valid, .pkt_ce_value,
        .pkt_cfg_valid, .pkt_cfg_res_sens_dis
    );
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic tmo;
        errors++;
        tally_and_finish();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
            if (n > 20) tmo();
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wait_pw(input logic l, input int m, output int c);
        c = 0;
        while (power_on !== l) begin
            @(posedge clk_sys);
            c++;
            if (c > m) tmo();
        end
    endtask
    task automatic ce(input logic [7:0] v);
        int p, q;
        p = (int'(coil_current_ma) * int'($signed(v))) >>> 7;
        q = p > LIM_VOLT ? LIM_VOLT : (p < -LIM_VOLT ? -LIM_VOLT : p);
        if (p > 0 && ed < D_MAX) ed = ed + p > D_MAX ? D_MAX : ed + p;
        else if (p > 0 && ef > F_MIN) ef = ef - p < F_MIN ? F_MIN : ef - p;
        else if (p > 0) ev = ev + q > V_MAX ? V_MAX : ev + q;
        else if (ef < F_MAX) ef = ef - p > F_MAX ? F_MAX : ef - p;
        else if (ev > V_MIN) ev = ev + q < V_MIN ? V_MIN : ev + q;
        else ed = ed + p < 0 ? 0 : ed + p;
        rx.send(1, v, 0);
        @(posedge clk_sys);
        chk("freq", ef, operating_frequency);
        chk("volt", ev, inverter_voltage);
        chk("duty", ed, duty_cycle);
    endtask
    task automatic t_reset;
        chk("power", 0, power_on);
        chk("freq", F_PING_HI, operating_frequency);
        apb(0, OFS_SS_MIN, 0);
        chk("ss_min", SS_MIN_RST, rd);
        chk("slverr_ok", 0, err);
        apb(0, 8'h40, 0);
        chk("slverr", 1, err);
        chk("rd_bad", 0, rd);
    endtask
    task automatic t_probe;
        int c;
        apb(1, OFS_CTRL, 1);
        for (int k = 0; k < 5; k++) begin
            wait_pw(1, PING_GAP_CYC + 10, c);
            chk("ping_f", F_PING_HI - k * F_PING_STEP, operating_frequency);
            chk("ping_v", V_PING, inverter_voltage);
            wait_pw(0, PING_WIN_CYC + 10, c);
            chk("ping_len", 1, c >= PING_WIN_CYC - 2);
        end
        apb(0, OFS_STATUS, 0);
        chk("fail", 1, rd[ST_FAIL_BIT]);
        apb(1, OFS_STATUS, 32'h40);
        apb(0, OFS_STATUS, 0);
        chk("fail_clr", 0, rd[ST_FAIL_BIT]);
        wait_pw(1, 10, c);
        chk("restart", F_PING_HI, operating_frequency);
        apb(1, OFS_SS_MIN, 32'h0000_0030);
        rx.send(0, 8'h20, 20);
        apb(0, OFS_STATUS, 0);
        chk("low_ss", ST_PING, rd[3:0]);
        rx.send(0, 8'h30, 3);
        @(posedge clk_sys);
        chk("x_volt", V_MAX, inverter_voltage);
        chk("x_duty", D_MAX, duty_cycle);
        apb(0, OFS_STATUS, 0);
        chk("st_xfer", ST_XFER, rd[3:0]);
        apb(0, OFS_VOLT, 0);
        chk("rd_volt", V_MAX, rd);
        apb(0, OFS_CUR, 0);
        chk("rd_cur", 32'h0000_0FFF, rd);
        rx.send(2, 8'h01, 3);
        apb(0, OFS_STATUS, 0);
        chk("cfg_err", 1, rd[ST_CFG_BIT]);
        apb(1, OFS_STATUS, 32'h0000_0080);
        apb(0, OFS_STATUS, 0);
        chk("cfg_clr", 0, rd[ST_CFG_BIT]);
    endtask
    task automatic t_xfer;
        int c;
        ef = F_PING_HI;
        ev = V_MAX;
        ed = D_MAX;
        for (int k = 0; k < 20; k++) ce(8'h80);
        ce(8'h01);
        ce(8'h7F);
        for (int k = 0; k < 25; k++) ce(8'h7F);
        clk_en <= 1'h0;
        rx.send(1, 8'h80, 0);
        @(posedge clk_sys);
        chk("frozen", ef, operating_frequency);
        clk_en <= 1'h1;
        apb(0, OFS_STATUS, 0);
        chk("path", PATH_VOLT, rd[5:4]);
        apb(0, OFS_FREQ, 0);
        chk("rd_freq", ef, rd);
        chk("power", 1, power_on);
        apb(1, OFS_CTRL, 0);
        wait_pw(0, 4, c);
    endtask
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = 44'h0;
        coil_current_ma = 12'hFFF;
        clk_en = 1'h1;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        t_reset();
        t_probe();
        t_xfer();
        tally_and_finish();
    end
endmodule
